// ==== design/lrb_defs.svh ====
// constants of the display read-back target: offsets, fields, resets, sizes
// assumes nothing; included by every design file that needs a figure
`ifndef LRB_DEFS_SVH
`define LRB_DEFS_SVH

// target address, upper six bits; the low bit comes from the strap pin
`define LRB_TARGET_HI 6'h1d

// control byte fields
`define LRB_CB_CONT 7
`define LRB_CB_RS 6

// instruction decode patterns
`define LRB_CMD_HOME 7'h01
`define LRB_CMD_ENTRY 6'h01
`define LRB_CMD_SHIFT 4'h1
`define LRB_CMD_ADDR_BIT 7

// display text ram and fifo
`define LRB_DTR_DEPTH 80
`define LRB_DTR_AW 7
`define LRB_DTR_LAST 7'h4f
`define LRB_DW 8
`define LRB_WORD_W 9
`define LRB_FIFO_DEPTH 16

// reset values
`define LRB_AC_RST 7'h00
`define LRB_SHIFT_RST 7'h00
`define LRB_RS_RST 1'b0
`define LRB_INCR_RST 1'b1
`define LRB_SEN_RST 1'b0
`define LRB_BYTE_RST 8'h00

`endif

// ==== design/lrb_pkg.sv ====
// types shared by the display read-back target
// assumes lrb_defs.svh holds every figure; this package holds only types
package lrb_pkg;

	// serial link states, gray along start-address-ack-data
	typedef enum logic [2:0] {
		L_IDLE = 3'h0,
		L_ADDR = 3'h1,
		L_ADDR_ACK = 3'h3,
		L_WR = 3'h2,
		L_WR_ACK = 3'h6,
		L_RD = 3'h7,
		L_RD_ACK = 3'h5,
		L_WAIT = 3'h4
	} lrb_link_t;

	// command executor states
	typedef enum logic {
		C_IDLE = 1'b0,
		C_FETCH = 1'b1
	} lrb_core_t;

endpackage : lrb_pkg

// ==== design/lrb_fifo.sv ====
// synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ns
`default_nettype none

module lrb_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
	logic do_wr, do_rd;

	// extra pointer bit tells full from empty
	assign in_ready = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
	assign out_valid = wr_reg != rd_reg;
	assign out_data = mem_reg[rd_reg[AW-1:0]];

	always_comb begin
		do_wr = in_valid && in_ready;
		do_rd = out_valid && out_ready;
		wr_next = do_wr ? wr_reg + 1'b1 : wr_reg;
		rd_next = do_rd ? rd_reg + 1'b1 : rd_reg;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	// storage holds no control state, so it carries no reset
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem_reg[wr_reg[AW-1:0]] <= in_data;
		end
	end

endmodule : lrb_fifo

`default_nettype wire

// ==== design/lrb_dtr_ram.sv ====
// display text ram: one write port, one read port with registered data
// assumes one clock; contents are undefined after power-up
`timescale 1ns/1ns
`default_nettype none
`include "lrb_defs.svh"

module lrb_dtr_ram (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// write port
	input wire logic we,
	input wire logic [`LRB_DTR_AW-1:0] waddr,
	input wire logic [`LRB_DW-1:0] wdata,
	// read port, data one cycle after the address
	input wire logic [`LRB_DTR_AW-1:0] raddr,
	output logic [`LRB_DW-1:0] rdata
);

	logic [`LRB_DW-1:0] mem_reg [`LRB_DTR_DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem_reg[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata <= `LRB_BYTE_RST;
		end else begin
			rdata <= mem_reg[raddr];
		end
	end

endmodule : lrb_dtr_ram

`default_nettype wire

// ==== design/lrb_core.sv ====
// two-wire target of a character display controller, read-back path
// assumes scl/sda already synchronous to clk and an external open-drain wire
`timescale 1ns/1ns
`default_nettype none
`include "lrb_defs.svh"

// How it works
// - home command clears address counter to zero
// - home cancels display shift, text untouched
// - home leaves read data register alone
// - read address ack loads data register out when select is one, status byte when zero
// - first byte undefined until address set or read
// - last control byte with select one reads ram
// - read byte shifted out msb first, eight clocks
// - master ack fetches next ram location when select is one
// - master nack causes no internal action
// - address low bit follows strap pin
// - register select holds until next control byte
module lrb_core (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// serial bus, sda open-drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// strap
	input wire logic address_strap_low_bit,
	// status
	output logic [`LRB_DTR_AW-1:0] addr_counter,
	output logic [`LRB_DTR_AW-1:0] display_shift,
	output logic entry_incr,
	output logic entry_shift,
	output logic register_select,
	output logic rd_data_known,
	output logic busy
);

	//----------------------------------------------------------------
	// shared helpers
	//----------------------------------------------------------------
	function automatic logic [`LRB_DTR_AW-1:0] lrb_adv(input logic [`LRB_DTR_AW-1:0] v,
		input logic up);
		if (up) begin
			lrb_adv = (v == `LRB_DTR_LAST) ? `LRB_AC_RST : v + 1'b1;
		end else begin
			lrb_adv = (v == `LRB_AC_RST) ? `LRB_DTR_LAST : v - 1'b1;
		end
	endfunction : lrb_adv

	lrb_pkg::lrb_link_t lstate_reg, lstate_next;
	lrb_pkg::lrb_core_t cstate_reg, cstate_next;
	logic scl_q, sda_q, strap_reg;
	logic scl_rise, scl_fall, start_cond, stop_cond;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next;
	logic oe_reg, oe_next, rw_reg, rw_next, rs_reg, rs_next;
	logic cont_reg, cont_next, ctrl_reg, ctrl_next, ack_reg, ack_next;
	logic push_valid, push_ready, rd_req, nack_pulse;
	logic [`LRB_WORD_W-1:0] fifo_q;
	logic fifo_valid, pop;
	logic [`LRB_DTR_AW-1:0] ac_reg, ac_next, dsh_reg, dsh_next;
	logic incr_reg, incr_next, sen_reg, sen_next, known_reg, known_next;
	logic lflag_reg, lflag_next, pend_reg, pend_next, shift_load, ram_we;
	logic [7:0] dr_reg, dr_next, ram_q, status_byte;

	assign scl_rise = scl_in && !scl_q;
	assign scl_fall = !scl_in && scl_q;
	assign start_cond = scl_in && scl_q && sda_q && !sda_in;
	assign stop_cond = scl_in && scl_q && !sda_q && sda_in;
	assign busy = fifo_valid || (cstate_reg != lrb_pkg::C_IDLE) || pend_reg;
	assign status_byte = {busy, ac_reg};
	assign sda_out = 1'b0;
	assign sda_oe = oe_reg;
	assign addr_counter = ac_reg;
	assign display_shift = dsh_reg;
	assign entry_incr = incr_reg;
	assign entry_shift = sen_reg;
	assign register_select = rs_reg;
	assign rd_data_known = known_reg;

	//----------------------------------------------------------------
	// serial link
	//----------------------------------------------------------------
	always_comb begin
		lstate_next = lstate_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		oe_next = oe_reg;
		rw_next = rw_reg;
		rs_next = rs_reg;
		cont_next = cont_reg;
		ctrl_next = ctrl_reg;
		ack_next = ack_reg;
		push_valid = 1'b0;
		rd_req = 1'b0;
		nack_pulse = 1'b0;
		unique case (lstate_reg)
			lrb_pkg::L_IDLE, lrb_pkg::L_WAIT: begin
			end
			lrb_pkg::L_ADDR, lrb_pkg::L_WR: begin
				if (scl_rise) begin
					sh_next = {sh_reg[6:0], sda_in};
					cnt_next = cnt_reg + 1'b1;
				end else if (scl_fall && cnt_reg == 4'h8) begin
					if (lstate_reg == lrb_pkg::L_ADDR) begin
						if (sh_reg[7:1] == {`LRB_TARGET_HI, strap_reg}) begin
							oe_next = 1'b1;
							rw_next = sh_reg[0];
							lstate_next = lrb_pkg::L_ADDR_ACK;
							if (sh_reg[0]) begin
								sh_next = rs_reg ? dr_reg : status_byte;
							end
						end else begin
							lstate_next = lrb_pkg::L_WAIT;
						end
					end else if (ctrl_reg) begin
						cont_next = sh_reg[`LRB_CB_CONT];
						rs_next = sh_reg[`LRB_CB_RS];
						ctrl_next = 1'b0;
						oe_next = 1'b1;
						lstate_next = lrb_pkg::L_WR_ACK;
					end else begin
						push_valid = 1'b1;
						// a full fifo refuses the byte with a nack
						if (push_ready) begin
							ctrl_next = cont_reg;
							oe_next = 1'b1;
							lstate_next = lrb_pkg::L_WR_ACK;
						end else begin
							lstate_next = lrb_pkg::L_WAIT;
						end
					end
				end
			end
			lrb_pkg::L_ADDR_ACK, lrb_pkg::L_WR_ACK: begin
				if (scl_fall) begin
					cnt_next = 4'h0;
					if (lstate_reg == lrb_pkg::L_ADDR_ACK && rw_reg) begin
						lstate_next = lrb_pkg::L_RD;
						oe_next = !sh_reg[7];
					end else begin
						lstate_next = lrb_pkg::L_WR;
						oe_next = 1'b0;
						if (lstate_reg == lrb_pkg::L_ADDR_ACK) begin
							ctrl_next = 1'b1;
						end
					end
				end
			end
			lrb_pkg::L_RD: begin
				if (scl_fall) begin
					if (cnt_reg == 4'h7) begin
						oe_next = 1'b0;
						ack_next = 1'b0;
						lstate_next = lrb_pkg::L_RD_ACK;
					end else begin
						sh_next = {sh_reg[6:0], 1'b0};
						cnt_next = cnt_reg + 1'b1;
						oe_next = !sh_reg[6];
					end
				end
			end
			lrb_pkg::L_RD_ACK: begin
				if (scl_rise) begin
					if (!sda_in) begin
						ack_next = 1'b1;
						rd_req = rs_reg;
					end else begin
						nack_pulse = 1'b1;
						lstate_next = lrb_pkg::L_WAIT;
					end
				end else if (shift_load) begin
					sh_next = dr_next;
				end else if (scl_fall && ack_reg) begin
					lstate_next = lrb_pkg::L_RD;
					cnt_next = 4'h0;
					if (!rs_reg) begin
						sh_next = status_byte;
						oe_next = !status_byte[7];
					end else begin
						oe_next = !sh_reg[7];
					end
				end
			end
		endcase
		if (stop_cond) begin
			lstate_next = lrb_pkg::L_IDLE;
			oe_next = 1'b0;
		end else if (start_cond) begin
			lstate_next = lrb_pkg::L_ADDR;
			cnt_next = 4'h0;
			oe_next = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lstate_reg <= lrb_pkg::L_IDLE;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			strap_reg <= 1'b0;
			cnt_reg <= 4'h0;
			sh_reg <= `LRB_BYTE_RST;
			oe_reg <= 1'b0;
			rw_reg <= 1'b0;
			rs_reg <= `LRB_RS_RST;
			cont_reg <= 1'b0;
			ctrl_reg <= 1'b1;
			ack_reg <= 1'b0;
		end else begin
			lstate_reg <= lstate_next;
			scl_q <= scl_in;
			sda_q <= sda_in;
			strap_reg <= address_strap_low_bit;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			oe_reg <= oe_next;
			rw_reg <= rw_next;
			rs_reg <= rs_next;
			cont_reg <= cont_next;
			ctrl_reg <= ctrl_next;
			ack_reg <= ack_next;
		end
	end

	//----------------------------------------------------------------
	// byte queue and text ram
	//----------------------------------------------------------------
	lrb_fifo #(
		.WIDTH(`LRB_WORD_W),
		.DEPTH(`LRB_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data({rs_reg, sh_reg}),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_q)
	);

	lrb_dtr_ram u_ram (
		.clk(clk),
		.sys_rst(sys_rst),
		.we(ram_we),
		.waddr(ac_reg),
		.wdata(fifo_q[7:0]),
		.raddr(ac_next),
		.rdata(ram_q)
	);

	//----------------------------------------------------------------
	// command executor
	//----------------------------------------------------------------
	always_comb begin
		cstate_next = cstate_reg;
		ac_next = ac_reg;
		dsh_next = dsh_reg;
		incr_next = incr_reg;
		sen_next = sen_reg;
		dr_next = dr_reg;
		known_next = known_reg;
		lflag_next = lflag_reg;
		pend_next = pend_reg || rd_req;
		pop = 1'b0;
		ram_we = 1'b0;
		shift_load = 1'b0;
		unique case (cstate_reg)
			lrb_pkg::C_IDLE: begin
				// a pending read outranks queued bytes so the ack window is met
				if (pend_reg || rd_req) begin
					pend_next = 1'b0;
					ac_next = lrb_adv(ac_reg, incr_reg);
					lflag_next = 1'b1;
					cstate_next = lrb_pkg::C_FETCH;
				end else if (fifo_valid) begin
					pop = 1'b1;
					if (fifo_q[8]) begin
						ram_we = 1'b1;
						ac_next = lrb_adv(ac_reg, incr_reg);
						if (sen_reg) begin
							dsh_next = lrb_adv(dsh_reg, incr_reg);
						end
					end else if (fifo_q[`LRB_CMD_ADDR_BIT]) begin
						ac_next = (fifo_q[6:0] > `LRB_DTR_LAST) ? `LRB_AC_RST : fifo_q[6:0];
						lflag_next = 1'b0;
						cstate_next = lrb_pkg::C_FETCH;
					end else if (fifo_q[7:1] == `LRB_CMD_HOME) begin
						ac_next = `LRB_AC_RST;
						dsh_next = `LRB_SHIFT_RST;
					end else if (fifo_q[7:2] == `LRB_CMD_ENTRY) begin
						incr_next = fifo_q[1];
						sen_next = fifo_q[0];
					end else if (fifo_q[7:4] == `LRB_CMD_SHIFT) begin
						if (fifo_q[3]) begin
							dsh_next = lrb_adv(dsh_reg, fifo_q[2]);
						end else begin
							ac_next = lrb_adv(ac_reg, fifo_q[2]);
						end
					end
				end
			end
			lrb_pkg::C_FETCH: begin
				dr_next = ram_q;
				known_next = 1'b1;
				shift_load = lflag_reg;
				cstate_next = lrb_pkg::C_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cstate_reg <= lrb_pkg::C_IDLE;
			ac_reg <= `LRB_AC_RST;
			dsh_reg <= `LRB_SHIFT_RST;
			incr_reg <= `LRB_INCR_RST;
			sen_reg <= `LRB_SEN_RST;
			dr_reg <= `LRB_BYTE_RST;
			known_reg <= 1'b0;
			lflag_reg <= 1'b0;
			pend_reg <= 1'b0;
		end else begin
			cstate_reg <= cstate_next;
			ac_reg <= ac_next;
			dsh_reg <= dsh_next;
			incr_reg <= incr_next;
			sen_reg <= sen_next;
			dr_reg <= dr_next;
			known_reg <= known_next;
			lflag_reg <= lflag_next;
			pend_reg <= pend_next;
		end
	end

	//----------------------------------------------------------------
	// checks
	//----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic home_pop;
	assign home_pop = pop && !fifo_q[8] && fifo_q[7:1] == `LRB_CMD_HOME && !pend_reg && !rd_req;

	home_ac_zero_a: assert property (home_pop |=> ac_reg == `LRB_AC_RST)
		else $error("home did not clear the address counter");
	home_shift_a: assert property (home_pop |-> !ram_we ##1 dsh_reg == `LRB_SHIFT_RST)
		else $error("home left a display shift or wrote text");
	home_keeps_dr_a: assert property (home_pop |=> $stable(dr_reg))
		else $error("home changed the read data register");
	rd_addr_load_a: assert property (lstate_next == lrb_pkg::L_ADDR_ACK && sh_reg[0] && rs_reg
		&& lstate_reg == lrb_pkg::L_ADDR |=> sh_reg == $past(dr_reg))
		else $error("read address ack did not load the data register");
	known_cause_a: assert property ($rose(known_reg) |-> $past(cstate_reg) == lrb_pkg::C_FETCH)
		else $error("read data became known without a fetch");
	msb_first_a: assert property (lstate_reg == lrb_pkg::L_RD |-> sda_oe == !sh_reg[7])
		else $error("read bit on sda differs from shift msb");
	ack_fetch_a: assert property (rd_req && cstate_reg == lrb_pkg::C_IDLE |=> shift_load)
		else $error("master ack did not fetch the next byte");
	nack_idle_a: assert property (nack_pulse && !pend_reg |=> ($stable(ac_reg) && !shift_load) [*3])
		else $error("action taken after a master nack");
	strap_match_a: assert property (lstate_reg == lrb_pkg::L_ADDR && lstate_next == lrb_pkg::L_ADDR_ACK
		|-> sh_reg[1] == strap_reg)
		else $error("address acked with wrong strap bit");
	rs_follow_a: assert property (lstate_reg == lrb_pkg::L_WR && ctrl_reg && scl_fall && cnt_reg == 4'h8
		|=> rs_reg == $past(sh_reg[`LRB_CB_RS]))
		else $error("register select not taken from control byte");
	ac_advance_a: assert property (rd_req && cstate_reg == lrb_pkg::C_IDLE && incr_reg
		&& ac_reg != `LRB_DTR_LAST |=> ac_reg == $past(ac_reg) + 1'b1)
		else $error("acked read did not advance the counter");

	cov_read_addr_c: cover property (lstate_reg == lrb_pkg::L_ADDR_ACK && rw_reg);
	cov_master_ack_c: cover property (rd_req ##[1:4] shift_load);
	cov_nack_c: cover property (nack_pulse);
	cov_fifo_full_c: cover property (push_valid && !push_ready);

endmodule : lrb_core

`default_nettype wire

// ==== tb/lrb_master.sv ====
// bus master model that drives the display read-back target
// assumes a pull-up on sda and one clock; the bus only moves just after clk edges
`timescale 1ns/1ns
`default_nettype none

module lrb_master #(
	parameter int HALF = 8
) (
	// clock
	input wire logic clk,
	// bus
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic pull_reg = 1'b0;
	logic scl_reg = 1'b1;

	// wired-and with a pull-up, so a released wire reads high
	assign sda = !(pull_reg || sda_oe);
	assign scl = scl_reg;

	task automatic wait_half();
		repeat (HALF) @(posedge clk);
	endtask : wait_half

	// also serves as repeated start when scl is low
	task automatic start();
		@(posedge clk) pull_reg <= 1'b0;
		wait_half();
		@(posedge clk) scl_reg <= 1'b1;
		wait_half();
		@(posedge clk) pull_reg <= 1'b1;
		wait_half();
		@(posedge clk) scl_reg <= 1'b0;
		wait_half();
	endtask : start

	task automatic stop();
		@(posedge clk) pull_reg <= 1'b1;
		wait_half();
		@(posedge clk) scl_reg <= 1'b1;
		wait_half();
		@(posedge clk) pull_reg <= 1'b0;
		wait_half();
	endtask : stop

	task automatic put_bit(input logic b);
		@(posedge clk) pull_reg <= !b;
		wait_half();
		@(posedge clk) scl_reg <= 1'b1;
		wait_half();
		@(posedge clk) scl_reg <= 1'b0;
	endtask : put_bit

	task automatic get_bit(output logic b);
		@(posedge clk) pull_reg <= 1'b0;
		wait_half();
		@(posedge clk) scl_reg <= 1'b1;
		wait_half();
		b = sda;
		@(posedge clk) scl_reg <= 1'b0;
	endtask : get_bit

	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i]);
		end
		get_bit(b);
		ack = !b;
	endtask : write_byte

	task automatic read_byte(input logic ack, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			get_bit(d[i]);
		end
		put_bit(!ack);
	endtask : read_byte
endmodule : lrb_master

`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the display read-back target
// assumes the master model owns the bus; clk is 50 MHz
`timescale 1ns/1ns
`default_nettype none
`include "lrb_defs.svh"

module testbench;
	// ----------------
	// wiring
	// ----------------
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic strap = 1'b0;
	logic scl;
	logic sda;
	logic sda_out;
	logic sda_oe;
	logic [`LRB_DTR_AW-1:0] addr_counter;
	logic [`LRB_DTR_AW-1:0] display_shift;
	logic entry_incr;
	logic entry_shift;
	logic register_select;
	logic rd_data_known;
	logic busy;
	logic ack;
	logic [7:0] rd;
	int n_mismatch = 0;
	int total_checks = 0;

	always #10 clk = !clk;

	lrb_master lrb_master_inst (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

	lrb_core lrb_core_inst (.clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .address_strap_low_bit(strap),
		.addr_counter(addr_counter), .display_shift(display_shift),
		.entry_incr(entry_incr), .entry_shift(entry_shift),
		.register_select(register_select), .rd_data_known(rd_data_known), .busy(busy));

	// ----------------
	// access tasks
	// ----------------
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic send(input logic [7:0] d, input logic exp_ack);
		lrb_master_inst.write_byte(d, ack);
		check("ack", {7'h00, exp_ack}, {7'h00, ack});
	endtask : send

	task automatic recv(input logic mack, input logic [7:0] exp);
		lrb_master_inst.read_byte(mack, rd);
		check("read data", exp, rd);
	endtask : recv

	// bounded wait for the executor; a hang shows up as a busy mismatch
	task automatic settle();
		int k;
		k = 0;
		repeat (4) @(posedge clk);
		while (busy !== 1'b0 && k < 200) begin
			@(posedge clk);
			k++;
		end
		check("busy", 8'h00, {7'h00, busy});
	endtask : settle

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done

	// ----------------
	// tests
	// ----------------
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		check("counter", 8'h00, {1'b0, addr_counter});
		check("shift", 8'h00, {1'b0, display_shift});
		check("incr", 8'h01, {7'h00, entry_incr});
		check("shift en", 8'h00, {7'h00, entry_shift});
		check("select", 8'h00, {7'h00, register_select});
		check("known", 8'h00, {7'h00, rd_data_known});
		check("sda out", 8'h00, {7'h00, sda_out});
		check("sda oe", 8'h00, {7'h00, sda_oe});
		// fill text ram 0..2 with 'P' 'H' 'I'
		lrb_master_inst.start();
		send({`LRB_TARGET_HI, 1'b0, 1'b0}, 1'b1);
		send(8'h80, 1'b1);
		send(8'h80, 1'b1);
		send(8'h40, 1'b1);
		send(8'h50, 1'b1);
		send(8'h48, 1'b1);
		send(8'h49, 1'b1);
		settle();
		check("counter", 8'h03, {1'b0, addr_counter});
		check("select", 8'h01, {7'h00, register_select});
		lrb_master_inst.stop();
		// set address 2 prefetches 'I', then shift and home must not disturb it
		lrb_master_inst.start();
		send({`LRB_TARGET_HI, 1'b0, 1'b0}, 1'b1);
		send(8'h80, 1'b1);
		send(8'h82, 1'b1);
		settle();
		check("counter", 8'h02, {1'b0, addr_counter});
		check("known", 8'h01, {7'h00, rd_data_known});
		send(8'h80, 1'b1);
		send(8'h18, 1'b1);
		settle();
		check("shifted", 8'h01, {7'h00, display_shift != 7'h00});
		send(8'h80, 1'b1);
		send(8'h02, 1'b1);
		settle();
		check("counter", 8'h00, {1'b0, addr_counter});
		check("shift", 8'h00, {1'b0, display_shift});
		send(8'h40, 1'b1);
		lrb_master_inst.start();
		send({`LRB_TARGET_HI, 1'b0, 1'b1}, 1'b1);
		recv(1'b1, 8'h49);
		recv(1'b1, 8'h48);
		recv(1'b0, 8'h49);
		lrb_master_inst.stop();
		settle();
		check("counter", 8'h02, {1'b0, addr_counter});
		// wrong strap level is ignored, matching one is taken
		lrb_master_inst.start();
		send({`LRB_TARGET_HI, 1'b1, 1'b0}, 1'b0);
		lrb_master_inst.stop();
		strap <= 1'b1;
		repeat (2) @(posedge clk);
		lrb_master_inst.start();
		send({`LRB_TARGET_HI, 1'b1, 1'b0}, 1'b1);
		send(8'h80, 1'b1);
		send(8'h04, 1'b1);
		settle();
		check("incr", 8'h00, {7'h00, entry_incr});
		check("counter", 8'h02, {1'b0, addr_counter});
		// a decrementing read walks the text ram backwards
		send(8'h40, 1'b1);
		lrb_master_inst.start();
		send({`LRB_TARGET_HI, 1'b1, 1'b1}, 1'b1);
		recv(1'b1, 8'h49);
		recv(1'b0, 8'h48);
		lrb_master_inst.stop();
		settle();
		check("counter", 8'h01, {1'b0, addr_counter});
		// select zero turns reads into status {busy, counter}
		lrb_master_inst.start();
		send({`LRB_TARGET_HI, 1'b1, 1'b0}, 1'b1);
		send(8'h00, 1'b1);
		lrb_master_inst.start();
		send({`LRB_TARGET_HI, 1'b1, 1'b1}, 1'b1);
		recv(1'b0, 8'h01);
		lrb_master_inst.stop();
		check("select", 8'h00, {7'h00, register_select});
		test_done();
	end

	// whole run is well under 20000 cycles
	initial begin
		repeat (50000) @(posedge clk);
		n_mismatch++;
		$display("[ERR] watchdog expected finish seen timeout");
		test_done();
	end
endmodule : testbench

`default_nettype wire
